/* hdl/vcs_cal_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vcs_defines.svh"
module vcs_cal_divider
	import vcs_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Link
	vcs_link_if.div link
);
	vcs_div_t s;
	vcs_div_t n;

	// Half period of the calibration clock in reference edges, minus one
	function automatic logic [2:0] halfCount(input logic [1:0] code);
		logic [2:0] h;
		h = `VCS_HALF_DIV16;
		if (code == `VCS_RATIO_DIV2)
			h = `VCS_HALF_DIV2; // see RULE_01
		else if (code == `VCS_RATIO_DIV4)
			h = `VCS_HALF_DIV4; // see RULE_02
		else if (code == `VCS_RATIO_DIV8)
			h = `VCS_HALF_DIV8; // see RULE_03
		else
			h = `VCS_HALF_DIV16; // see RULE_04 see RULE_05
		return h;
	endfunction

	always_comb
	begin
		n = s;
		n.calTick = 1'b0;
		if (link.refRise)
		begin
			if (s.cnt >= halfCount(link.ratio))
			begin
				n.cnt = 3'h0;
				n.calClk = ~s.calClk;
				n.calTick = ~s.calClk;
			end
			else
				n.cnt = s.cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= n;
	end

	assign link.calTick = s.calTick;
	assign link.calClk = s.calClk;
endmodule
`default_nettype wire

/* hdl/vcs_calibration_ctrl.sv */
// What this block and its software must do
// RULE_01 - Code 00 divides reference by two
// RULE_02 - Code 01 divides reference by four
// RULE_03 - Code 10 divides reference by eight
// RULE_04 - Divide-by-16 is the reset default
// RULE_05 - Code 11 also divides by sixteen
// RULE_06 - Start calibration on active start bit rising
// RULE_07 - Software checks reference, then toggles start
// RULE_08 - Clearing start discards the calibration result
// RULE_09 - Software keeps holdover off during calibration
// RULE_10 - Sync mode field selects counter reset
// RULE_11 - Code 11 leaves counters alone on sync
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vcs_defines.svh"
module vcs_calibration_ctrl
	import vcs_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Pins
	input wire logic refClkIn,
	input wire logic syncIn,
	input wire logic refPresentIn,
	// Calibration
	output logic calClk,
	output logic calBusy,
	output logic calValid,
	output logic calDiscard,
	// Counter resets
	output logic counterResetAsync,
	output logic counterResetSync
);
	vcs_top_t s;
	vcs_top_t n;
	vcs_link_if link();

	logic [9:0] idx;
	logic setup;
	logic access;
	logic startRise;
	logic startFall;
	logic [1:0] mode;

	// Address decode shared by read and write
	function automatic logic isMapped(input logic [9:0] a);
		logic m;
		m = 1'b0;
		if (a == `VCS_IDX_CAL)
			m = 1'b1;
		else if (a == `VCS_IDX_SYNC)
			m = 1'b1;
		else if (a == `VCS_IDX_UPDATE)
			m = 1'b1;
		else if (a == `VCS_IDX_STATUS)
			m = 1'b1;
		return m;
	endfunction

	assign link.refRaw = refClkIn;
	assign link.syncRaw = syncIn;
	assign link.presentRaw = refPresentIn;
	assign link.ratio = s.calAct[`VCS_RATIO_MSB:`VCS_RATIO_LSB];

	vcs_pin_sync u_sync
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.link(link.sync)
	);

	vcs_cal_divider u_div
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.link(link.div)
	);

	assign idx = paddr[11:2];
	assign setup = psel & ~penable;
	assign access = psel & penable & s.pready;
	assign startRise = s.calAct[`VCS_START_BIT] & ~s.prevStart;
	assign startFall = ~s.calAct[`VCS_START_BIT] & s.prevStart;
	assign mode = s.syncAct[`VCS_MODE_MSB:`VCS_MODE_LSB];

	always_comb
	begin
		n = s;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.calDiscard = 1'b0;
		n.cntRstSync = 1'b0;

		// Setup cycle: answer in the first access cycle
		if (setup)
		begin
			n.pready = 1'b1;
			n.pslverr = ~isMapped(idx);
			n.prdata = 32'h0;
			if (!pwrite)
			begin
				if (idx == `VCS_IDX_CAL)
					n.prdata = {29'h0, s.calBuf};
				else if (idx == `VCS_IDX_SYNC)
					n.prdata = {24'h0, s.syncBuf};
				else if (idx == `VCS_IDX_STATUS)
					n.prdata = {28'h0, link.syncLevel, link.refPresent,
						s.calValid, s.busy};
			end
		end

		// Buffered writes, copied to active set by update
		if (access && pwrite)
		begin
			if (idx == `VCS_IDX_CAL)
				n.calBuf = pwdata[2:0];
			else if (idx == `VCS_IDX_SYNC)
				n.syncBuf = pwdata[7:0];
			else if (idx == `VCS_IDX_UPDATE)
			begin
				if (pwdata[`VCS_UPDATE_BIT])
				begin
					n.calAct = s.calBuf; // see RULE_07
					n.syncAct = s.syncBuf;
				end
			end
		end

		// Calibration sequencer
		n.prevStart = s.calAct[`VCS_START_BIT];
		case (s.calState)
			CAL_IDLE:
			begin
				if (startRise)
				begin
					n.calState = CAL_RUN; // see RULE_06
					n.tickCnt = 16'h0;
					n.calValid = 1'b0;
				end
			end
			CAL_RUN:
			begin
				if (link.calTick)
				begin
					if (s.tickCnt == `VCS_CAL_TICKS - 16'h1)
					begin
						n.calState = CAL_IDLE;
						n.calValid = 1'b1;
					end
					else
						n.tickCnt = s.tickCnt + 16'h1;
				end
			end
			default:
				n.calState = CAL_IDLE;
		endcase
		if (startFall)
		begin
			n.calState = CAL_IDLE; // see RULE_08
			n.calValid = 1'b0;
			n.calDiscard = 1'b1;
		end
		n.busy = (n.calState == CAL_RUN);

		// Counter reset on sync input
		n.cntRstAsync = 1'b0;
		if (mode == `VCS_MODE_ASYNC)
			n.cntRstAsync = link.syncLevel; // see RULE_10
		else if (mode == `VCS_MODE_SYNC)
			n.cntRstSync = link.syncLevel & link.refRise; // see RULE_10
		else
			n.cntRstAsync = 1'b0; // see RULE_11
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
			s.calBuf <= `VCS_CAL_RESET; // see RULE_04
			s.calAct <= `VCS_CAL_RESET;
			s.syncBuf <= `VCS_SYNC_RESET;
			s.syncAct <= `VCS_SYNC_RESET;
			s.calState <= CAL_IDLE;
		end
		else
			s <= n;
	end

	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign calClk = link.calClk;
	assign calBusy = s.busy;
	assign calValid = s.calValid;
	assign calDiscard = s.calDiscard;
	assign counterResetAsync = s.cntRstAsync;
	assign counterResetSync = s.cntRstSync;
endmodule
`default_nettype wire

/* hdl/vcs_defines.svh */
`ifndef VCS_DEFINES_SVH
`define VCS_DEFINES_SVH

// Register indices; byte address is four times the index
`define VCS_IDX_CAL 10'h018
`define VCS_IDX_SYNC 10'h019
`define VCS_IDX_UPDATE 10'h232
`define VCS_IDX_STATUS 10'h233

// Reset values
`define VCS_CAL_RESET 3'h6
`define VCS_SYNC_RESET 8'h00

// Field positions
`define VCS_START_BIT 0
`define VCS_RATIO_MSB 2
`define VCS_RATIO_LSB 1
`define VCS_MODE_MSB 7
`define VCS_MODE_LSB 6
`define VCS_UPDATE_BIT 0

// Calibration clock ratio codes
`define VCS_RATIO_DIV2 2'h0
`define VCS_RATIO_DIV4 2'h1
`define VCS_RATIO_DIV8 2'h2
`define VCS_RATIO_DIV16 2'h3

// Reference edges per calibration clock half period, minus one
`define VCS_HALF_DIV2 3'h0
`define VCS_HALF_DIV4 3'h1
`define VCS_HALF_DIV8 3'h3
`define VCS_HALF_DIV16 3'h7

// Counter sync-reset modes
`define VCS_MODE_NONE 2'h0
`define VCS_MODE_ASYNC 2'h1
`define VCS_MODE_SYNC 2'h2
`define VCS_MODE_NONE2 2'h3

// Calibration length in calibration clock cycles
`define VCS_CAL_TICKS 16'h0100

`endif

/* hdl/vcs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vcs_link_if;
	logic refRaw;
	logic syncRaw;
	logic presentRaw;
	logic refRise;
	logic syncLevel;
	logic refPresent;
	logic [1:0] ratio;
	logic calTick;
	logic calClk;
	modport sync (input refRaw, syncRaw, presentRaw,
		output refRise, syncLevel, refPresent);
	modport div (input refRise, ratio, output calTick, calClk);
	modport core (output refRaw, syncRaw, presentRaw, ratio,
		input refRise, syncLevel, refPresent, calTick, calClk);
endinterface
`default_nettype wire

/* hdl/vcs_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module vcs_pin_sync
	import vcs_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Link
	vcs_link_if.sync link
);
	vcs_sync_t s;
	vcs_sync_t n;

	always_comb
	begin
		n = s;
		n.stage1 = {link.presentRaw, link.syncRaw, link.refRaw};
		n.stage2 = s.stage1;
		n.refPrev = s.stage2[0];
		n.refRise = s.stage2[0] & ~s.refPrev;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= n;
	end

	assign link.refRise = s.refRise;
	assign link.syncLevel = s.stage2[1];
	assign link.refPresent = s.stage2[2];
endmodule
`default_nettype wire

/* hdl/vcs_pkg.sv */
package vcs_pkg;

	typedef enum logic {CAL_IDLE, CAL_RUN} vcs_cal_state_t;

	typedef struct packed {
		logic [2:0] calBuf;
		logic [7:0] syncBuf;
		logic [2:0] calAct;
		logic [7:0] syncAct;
		logic prevStart;
		vcs_cal_state_t calState;
		logic [15:0] tickCnt;
		logic calValid;
		logic busy;
		logic calDiscard;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic cntRstAsync;
		logic cntRstSync;
	} vcs_top_t;

	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
		logic refPrev;
		logic refRise;
	} vcs_sync_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic calClk;
		logic calTick;
	} vcs_div_t;

endpackage

/* testbench/vcs_calibration_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module vcs_calibration_ctrl_bench;
	logic clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, refClkIn = 1'h0, syncIn = 1'h0, err;
	logic refPresentIn = 1'h1;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, calClk, calBusy, calValid, calDiscard;
	logic counterResetAsync, counterResetSync;
	int errCount = 0, checksDone = 0, seed = 5722, rc = 0, n, na, ns, i;
	// Model of buffered and active register sets
	int mCal = 6, mSync = 0, aCal = 6, aSync = 0;
	time t;
	always #5 clk_sys = ~clk_sys;
	// Reference of eight system clocks
	always @(posedge clk_sys)
	begin
		rc <= rc + 1;
		if (rc % 4 == 3)
			refClkIn <= ~refClkIn;
	end
	vcs_calibration_ctrl uut (.clk_sys, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .refClkIn, .syncIn,
		.refPresentIn, .calClk, .calBusy, .calValid, .calDiscard,
		.counterResetAsync, .counterResetSync);
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checksDone++;
		if (s !== e)
		begin
			errCount++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (w && a == 12'h060)
			mCal = d & 32'h7;
		else if (w && a == 12'h064)
			mSync = d & 32'hFF;
		else if (w && a == 12'h8C8 && d[0])
		begin
			aCal = mCal;
			aSync = mSync;
		end
	endtask
	task upd;
		apb(1'h1, 12'h8C8, 32'h1);
	endtask
	task period(input int r);
		@(posedge calClk);
		@(posedge calClk);
		t = $time;
		@(posedge calClk);
		chk("calClk period", 32'(($time - t) / 10), 32'(r * 8));
	endtask
	task wrapUp;
		$display("checks %0d errors %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#300us;
		errCount++;
		wrapUp;
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'h1;
		apb(1'h0, 12'h060, 32'h0);
		chk("cal reset", rd, 32'(mCal));
		period(2 << ((aCal >> 1) & 3));
		for (i = 0; i < 4; i++)
		begin
			apb(1'h1, 12'h060, 32'(i * 2));
			upd;
			period(2 << ((aCal >> 1) & 3));
		end
		refPresentIn <= 1'h0;
		repeat (4) @(posedge clk_sys);
		apb(1'h0, 12'h8CC, 32'h0);
		chk("ref absent", rd, 32'h0);
		refPresentIn <= 1'h1;
		repeat (4) @(posedge clk_sys);
		apb(1'h0, 12'h8CC, 32'h0);
		chk("ref present", rd, 32'h4);
		chk("status err", 32'(err), 32'h0);
		apb(1'h1, 12'h060, 32'h0);
		upd;
		apb(1'h1, 12'h060, 32'h1);
		upd;
		repeat (4) @(posedge clk_sys);
		chk("busy", 32'(calBusy), 32'h1);
		for (n = 0; n < 9000 && calValid !== 1'h1; n++)
			@(posedge clk_sys);
		chk("valid", 32'(calValid), 32'h1);
		na = int'(n >= 16 * 255 - 1 && n <= 16 * 256 - 2);
		chk("cal length", 32'(na), 32'h1);
		chk("busy end", 32'(calBusy), 32'h0);
		apb(1'h1, 12'h060, 32'h0);
		upd;
		na = 0;
		repeat (4)
		begin
			@(posedge clk_sys);
			na += int'(calDiscard);
		end
		chk("discard", 32'(na), 32'h1);
		chk("valid cleared", 32'(calValid), 32'h0);
		for (i = 0; i < 4; i++)
		begin
			n = ($random(seed) & 32'h3F) | (i << 6);
			apb(1'h1, 12'h064, 32'(n));
			upd;
			apb(1'h0, 12'h064, 32'h0);
			chk("sync reg", rd, 32'(mSync));
			syncIn <= 1'h1;
			na = 0;
			ns = 0;
			repeat (40)
			begin
				@(posedge clk_sys);
				na += int'(counterResetAsync);
				ns += int'(counterResetSync);
			end
			syncIn <= 1'h0;
			repeat (20) @(posedge clk_sys);
			chk("async", 32'(na > 30), 32'(((aSync >> 6) & 3) == 1));
			chk("sync", 32'(ns > 3), 32'(((aSync >> 6) & 3) == 2));
		end
		apb(1'h0, 12'hFFC, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		wrapUp;
	end
endmodule
`default_nettype wire

/* testbench/vcs_calibration_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vcs_ctrl_properties (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Pins and outputs
	input wire logic syncIn,
	input wire logic calBusy,
	input wire logic calValid,
	input wire logic calDiscard,
	input wire logic counterResetAsync,
	input wire logic counterResetSync
);
	wire logic updW;
	assign updW = psel & penable & pwrite & pready & pwdata[0]
		& (paddr[11:2] == 10'h232);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_start_update: assert property (
		$rose(calBusy) |-> $past(updW, 2) || $past(updW, 3))
		else $error("busy rose without update");
	a_busy_end: assert property (
		calBusy |=> calBusy || calValid || calDiscard)
		else $error("busy ended without result");
	a_discard_clear: assert property (
		calDiscard |=> !calBusy && !calValid)
		else $error("result kept after discard");
	a_discard_pulse: assert property (
		calDiscard |=> !calDiscard) else $error("discard too long");
	a_valid_hold: assert property (
		$fell(calValid) |-> $past(updW, 2) || $past(updW, 3))
		else $error("result lost without update");
	a_async_cause: assert property (
		$rose(counterResetAsync) |-> $past(syncIn, 2))
		else $error("async reset without sync");
	a_sync_pulse: assert property (
		counterResetSync |=> !counterResetSync)
		else $error("sync reset too long");
	a_idle_quiet: assert property (
		(!syncIn)[*8] |-> !counterResetAsync && !counterResetSync)
		else $error("counter reset without sync");
	a_modes_excl: assert property (
		!(counterResetAsync && counterResetSync))
		else $error("both counter resets");
	cover property ($fell(calBusy) && calValid);
	cover property (calDiscard);
	cover property (counterResetAsync);
	cover property (counterResetSync);
endmodule
bind vcs_calibration_ctrl vcs_ctrl_properties chk (.clk_sys, .reset_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .syncIn, .calBusy,
	.calValid, .calDiscard, .counterResetAsync, .counterResetSync);
`default_nettype wire
